/* design/aar_commit.sv */
// Purpose: holds the advertisement word that the negotiation engine actually uses
// Assumes: commit is a one-cycle pulse from the register bank on the same clock
// Notes: the live word only moves on commit, so register writes alone never reach the link
module aar_commit
	import aar_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// from the register bank
	input wire logic commit,
	input wire logic [REG_W-1:0] shadow_word,
	// to the negotiation engine
	output logic [REG_W-1:0] active_word,
	output logic restart_out
);

	logic [REG_W-1:0] active_reg;
	logic restart_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= AUTONEG_ADV_RESET;
		end else if (commit) begin
			active_reg <= shadow_word;
		end
	end

	// restart strobe lines up with the new word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= commit;
		end
	end

	assign active_word = active_reg;
	assign restart_out = restart_reg;

endmodule

/* design/aar_pkg.sv */
// Purpose: constants for the auto-negotiation advertisement register block
// Assumes: one 40 MHz clock, APB register access with 32-bit data
// Notes: field positions and reset values are shared by the design and its checks
//
// Contract
// - ability field bits 8:5 offered to partner
// - software may overwrite the ability bits
// - new values used only after restart
// - register at 0x04 resets to 0x01e1
// - bit 15 read-only, reads zero
// - bit 13 writable, advertises remote fault
// - bits 8,7,6 mean 100 fd, 100 hd, 10 fd
package aar_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;

	// byte addresses on the register bus
	localparam logic [7:0] PHY_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] AUTONEG_ADV_OFFSET = 8'h04;

	// advertisement register layout
	localparam int unsigned NEXT_PAGE_BIT = 15;
	localparam int unsigned RSVD_HI_BIT = 14;
	localparam int unsigned REMOTE_FAULT_BIT = 13;
	localparam int unsigned RSVD_LO_MSB = 12;
	localparam int unsigned RSVD_LO_LSB = 9;
	localparam int unsigned TECH_MSB = 8;
	localparam int unsigned TECH_LSB = 5;
	localparam int unsigned SEL_MSB = 4;
	localparam int unsigned SEL_LSB = 0;

	// meaning of the ability bits
	localparam int unsigned ABIL_100TX_FD_BIT = 8;
	localparam int unsigned ABIL_100TX_HD_BIT = 7;
	localparam int unsigned ABIL_10T_FD_BIT = 6;
	localparam int unsigned ABIL_10T_HD_BIT = 5;

	// fixed and reset values
	localparam logic [15:0] AUTONEG_ADV_RESET = 16'h01e1;
	localparam logic [3:0] TECH_RESET = 4'hf;
	localparam logic REMOTE_FAULT_RESET = 1'b0;
	localparam logic NEXT_PAGE_VALUE = 1'b0;
	localparam logic [4:0] SELECTOR_VALUE = 5'h01;

	// control register layout
	localparam int unsigned RESTART_AUTONEG_BIT = 9;
	localparam int unsigned ADV_PENDING_BIT = 0;

endpackage

/* design/aar_regs.sv */
// Purpose: APB register bank for the auto-negotiation advertisement word
// Assumes: APB master holds the request until pready; single clock pclk at 40 MHz
// Notes: every transfer answers after one wait cycle; unmapped addresses answer pslverr
//
// Chosen here: the APB register port.
module aar_regs
	import aar_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// towards the negotiation engine
	output logic [REG_W-1:0] adv_word,
	output logic adv_restart
);

	logic pready_reg;
	logic pslverr_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic [3:0] tech_reg;
	logic remote_fault_reg;
	logic restart_reg;
	logic pending_reg;
	logic access;
	logic done;
	logic hit_adv;
	logic hit_ctrl;
	logic wr_adv;
	logic wr_ctrl_restart;
	logic [REG_W-1:0] shadow_word;
	logic [REG_W-1:0] ctrl_word;
	logic [REG_W-1:0] active_word;
	logic restart_out;

	// transfer decode; done marks the edge where the master samples pready
	assign access = psel && penable;
	assign done = access && pready_reg;
	assign hit_adv = (paddr == AUTONEG_ADV_OFFSET);
	assign hit_ctrl = (paddr == PHY_CTRL_OFFSET);
	assign wr_adv = done && pwrite && hit_adv;
	assign wr_ctrl_restart = done && pwrite && hit_ctrl && pwdata[RESTART_AUTONEG_BIT];

	always_comb begin
		shadow_word = '0;
		shadow_word[NEXT_PAGE_BIT] = NEXT_PAGE_VALUE;
		shadow_word[RSVD_HI_BIT] = 1'b0;
		shadow_word[REMOTE_FAULT_BIT] = remote_fault_reg;
		shadow_word[RSVD_LO_MSB:RSVD_LO_LSB] = 4'h0;
		// top ability bit is 100 fd
		shadow_word[TECH_MSB:TECH_LSB] = tech_reg;
		shadow_word[SEL_MSB:SEL_LSB] = SELECTOR_VALUE;
	end

	// control readback: restart always reads zero, pending shows an uncommitted write
	always_comb begin
		ctrl_word = '0;
		ctrl_word[ADV_PENDING_BIT] = pending_reg;
	end

	// one wait cycle keeps pready a plain flop at the cost of a slower bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access && !pready_reg;
		end
	end

	// error flag set for any address outside the two words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (access && !pready_reg) begin
			pslverr_reg <= !(hit_adv || hit_ctrl);
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	// read data captured together with pready, upper half zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (access && !pready_reg && !pwrite) begin
			if (hit_adv) begin
				prdata_reg <= {16'h0000, shadow_word};
			end else if (hit_ctrl) begin
				prdata_reg <= {16'h0000, ctrl_word};
			end else begin
				prdata_reg <= '0;
			end
		end else begin
			prdata_reg <= '0;
		end
	end

	// ability field resets to all ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tech_reg <= TECH_RESET;
		end else if (wr_adv) begin
			tech_reg <= pwdata[TECH_MSB:TECH_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_fault_reg <= REMOTE_FAULT_RESET;
		end else if (wr_adv) begin
			remote_fault_reg <= pwdata[REMOTE_FAULT_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= wr_ctrl_restart;
		end
	end

	// a fresh write wins over a commit in the same cycle so it is never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= 1'b0;
		end else if (wr_adv) begin
			pending_reg <= 1'b1;
		end else if (restart_reg) begin
			pending_reg <= 1'b0;
		end
	end

	aar_commit u_commit (
		.pclk(pclk),
		.presetn(presetn),
		.commit(restart_reg),
		.shadow_word(shadow_word),
		.active_word(active_word),
		.restart_out(restart_out)
	);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign adv_word = active_word;
	assign adv_restart = restart_out;

	// helper: true until the first completed write to the advertisement word
	logic untouched_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			untouched_reg <= 1'b1;
		end else if (wr_adv) begin
			untouched_reg <= 1'b0;
		end
	end

	// bus phases
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_adv_read;
		psel && penable && pready_reg && !pwrite && hit_adv;
	endsequence

	sequence s_adv_write;
		psel && penable && pready_reg && pwrite && hit_adv;
	endsequence

	sequence s_restart_cmd;
		psel && penable && pready_reg && pwrite && hit_ctrl && pwdata[RESTART_AUTONEG_BIT];
	endsequence

	chk_reset_value: assert property (
		@(posedge pclk) disable iff (!presetn)
		untouched_reg |-> (shadow_word == AUTONEG_ADV_RESET)
	) else $error("advertisement word differs from its reset value before any write");

	chk_tech_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_adv_write |=> (prdata_reg == '0) && (tech_reg == $past(pwdata[TECH_MSB:TECH_LSB]))
	) else $error("ability field did not take the written value");

	chk_fault_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_adv_write |=> (shadow_word[REMOTE_FAULT_BIT] == $past(pwdata[REMOTE_FAULT_BIT]))
	) else $error("remote fault bit did not take the written value");

	chk_fixed_fields: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_adv_read |-> (prdata_reg[SEL_MSB:SEL_LSB] == SELECTOR_VALUE)
			&& (prdata_reg[RSVD_LO_MSB:RSVD_LO_LSB] == 4'h0)
	) else $error("selector or reserved field read wrong");

	chk_next_page: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_adv_read |-> !prdata_reg[NEXT_PAGE_BIT] && (prdata_reg[DATA_W-1:REG_W] == 16'h0000)
	) else $error("next page bit or upper half read nonzero");

	chk_no_effect: assert property (
		@(posedge pclk) disable iff (!presetn)
		!restart_reg |=> $stable(active_word)
	) else $error("live advertisement changed without a restart");

	chk_restart_commit: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_restart_cmd ##1 restart_reg |=> adv_restart && (adv_word == $past(shadow_word))
	) else $error("restart did not load the written advertisement");

	chk_mode_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		restart_reg |=> (adv_word[ABIL_100TX_FD_BIT] == $past(tech_reg[3]))
			&& (adv_word[ABIL_100TX_HD_BIT] == $past(tech_reg[2]))
			&& (adv_word[ABIL_10T_FD_BIT] == $past(tech_reg[1]))
	) else $error("ability bit landed in the wrong mode position");

	chk_partner_field: assert property (
		@(posedge pclk) disable iff (!presetn)
		adv_restart |-> (adv_word[TECH_MSB:TECH_LSB] == $past(tech_reg, 2))
	) else $error("offered ability field differs from the committed one");

	chk_ready_timing: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_setup ##1 (psel && penable) |=> pready ##1 !pready
	) else $error("pready not a single pulse after the first access cycle");

	chk_unmapped_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready_reg && !hit_adv && !hit_ctrl) |-> pslverr
	) else $error("unmapped address answered without error");

endmodule

/* dv/aar_partner.sv */
// Purpose: model of the negotiation engine fed by the live advertisement
// Assumes: adv_restart is a one-cycle pulse on pclk
// Notes: adv_word is ignored between pulses, as the real engine would
module aar_partner
	import aar_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// live advertisement
	input wire logic [REG_W-1:0] adv_word,
	input wire logic adv_restart,
	// what the link partner is offered
	output logic [3:0] offered_modes,
	output logic offered_fault
);
	timeunit 1ns;
	timeprecision 100ps;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offered_modes <= TECH_RESET;
			offered_fault <= REMOTE_FAULT_RESET;
		end else if (adv_restart) begin
			offered_modes <= adv_word[TECH_MSB:TECH_LSB];
			offered_fault <= adv_word[REMOTE_FAULT_BIT];
		end
	end
endmodule

/* dv/autoneg_advertisement_register_tb.sv */
// Purpose: self-checking bench for the advertisement register bank
// Assumes: one wait state per transfer, restart pulse after the control write
// Notes: reads and restarts are checked from queues of expected notes
module autoneg_advertisement_register_tb
	import aar_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adv_restart, offered_fault;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, w;
	logic [REG_W-1:0] adv_word, exp_adv, live_exp;
	logic [3:0] offered_modes;
	logic [32:0] rd_q[$];
	logic [15:0] adv_q[$];
	logic [31:0] seed = 32'h24;
	int errors, compares;

	aar_regs aar_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adv_word(adv_word), .adv_restart(adv_restart));
	aar_partner aar_partner_inst (.pclk(pclk), .presetn(presetn), .adv_word(adv_word),
		.adv_restart(adv_restart), .offered_modes(offered_modes), .offered_fault(offered_fault));

	// clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	function logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task test_done();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// request stays up until pready; release is left to idle so back to back works
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			test_done();
		end
	endtask

	task rd(input logic [7:0] a, input logic [32:0] exp);
		rd_q.push_back(exp);
		apb(1'b0, a, xorshift());
	endtask

	task idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// watcher: oldest note against each read answer and each restart
	always @(posedge pclk) begin
		if (pready === 1'b1 && psel && !pwrite) begin
			check("read data", {pslverr, prdata}, rd_q.pop_front());
		end
		if (adv_restart === 1'b1) begin
			check("live word", {17'h0, adv_word}, {17'h0, adv_q.pop_front()});
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		live_exp = AUTONEG_ADV_RESET;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		check("reset word", {17'h0, adv_word}, {17'h0, AUTONEG_ADV_RESET});
		rd(AUTONEG_ADV_OFFSET, {17'h0, AUTONEG_ADV_RESET});
		// all ones, all zeros, then random words; read-only bits must not move
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : xorshift();
			// random writes keep reserved bits as read back
			if (i > 1) w = w & 32'hffff_a1ff;
			exp_adv = (w[15:0] & 16'h21e0) | 16'h0001;
			apb(1'b1, AUTONEG_ADV_OFFSET, w);
			rd(AUTONEG_ADV_OFFSET, {17'h0, exp_adv});
			rd(PHY_CTRL_OFFSET, {1'b0, 32'h1});
			idle();
			check("held word", {17'h0, adv_word}, {17'h0, live_exp});
			adv_q.push_back(exp_adv);
			apb(1'b1, PHY_CTRL_OFFSET, 32'h0000_0200);
			idle();
			for (int n = 0; n < 8 && adv_q.size() != 0; n++) begin
				@(posedge pclk);
			end
			if (adv_q.size() != 0) begin
				errors++;
				test_done();
			end
			@(posedge pclk);
			check("modes", {29'h0, offered_modes}, {29'h0, exp_adv[8:5]});
			check("fault", {32'h0, offered_fault}, {32'h0, exp_adv[13]});
			live_exp = exp_adv;
			rd(PHY_CTRL_OFFSET, {1'b0, 32'h0});
		end
		// unmapped place: write ignored, read refused, register untouched
		apb(1'b1, 8'h08, 32'hffff_ffff);
		rd(8'h08, {1'b1, 32'h0});
		rd(AUTONEG_ADV_OFFSET, {17'h0, live_exp});
		idle();
		test_done();
	end
endmodule
